// *** hdl/dcf_pkg.sv ***
package dcf_pkg;

	// ----------------------------------------------------------------
	// Widths and defaults
	// ----------------------------------------------------------------
	localparam int          DCF_DATA_W        = 9;
	localparam int          DCF_DEPTH_DEF     = 64;
	localparam int          DCF_DEPTH_MAX     = 4096;
	localparam int          DCF_OFFSET_DEF    = 7;
	localparam int          DCF_SYNC_STAGES   = 2;

	// ----------------------------------------------------------------
	// Reset values of the pin flags
	// ----------------------------------------------------------------
	localparam logic        DCF_FULL_N_RST    = 1'h1;
	localparam logic        DCF_AFULL_N_RST   = 1'h1;
	localparam logic        DCF_EMPTY_N_RST   = 1'h0;
	localparam logic        DCF_AEMPTY_N_RST  = 1'h0;

	// ----------------------------------------------------------------
	// Modes and offset sequencer states
	// ----------------------------------------------------------------
	typedef enum logic {
		DCF_MODE_PROG = 1'b0,
		DCF_MODE_DUAL = 1'b1
	} dcf_mode_t;

	typedef enum logic {
		DCF_OFS_EMPTY = 1'b0,
		DCF_OFS_FULL  = 1'b1
	} dcf_ofs_t;

	typedef struct packed {
		logic full_n;
		logic almost_full_n;
	} dcf_wr_flags_t;

	typedef struct packed {
		logic empty_n;
		logic almost_empty_n;
	} dcf_rd_flags_t;

endpackage

// *** hdl/dcf_fifo.sv ***
// Operation
// - Storage of 9-bit words, depth 64 to 4096
// - Nine-bit write_data in, read_data out
// - Store word on enabled write clock edge
// - Read clock may be same or independent
// - Output enable copied to read_data_oe_n, data not three-stated
// - Almost offsets default to seven after reset
// - Offset loading run by small state machine
// - Reset returns both pointers to start
// - Reset drives full flags high, empty low
// - Mode pin sampled during reset
// - High at reset: second write enable
// - Low at reset: offset load control
// - Dual mode writes on enable_a low, b high
// - Load mode writes when enable_a low and load high
// - Writes ignored while full flag low
// - Read when both read enables low, not empty
// - Empty flag exact, read clock, blocks reads
// - Full flag exact, write clock, blocks writes
// - Almost flags follow programmed offsets
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo
	import dcf_pkg::*;
#(
	parameter int DEPTH = DCF_DEPTH_DEF
) (
	input  wire  logic                  write_clock,
	input  wire  logic                  read_clock,
	input  wire  logic                  master_reset_n,
	input  wire  logic [DCF_DATA_W-1:0] write_data,
	input  wire  logic                  write_enable_a_n,
	input  wire  logic                  write_enable_second_or_load,
	input  wire  logic                  read_enable_a_n,
	input  wire  logic                  read_enable_b_n,
	input  wire  logic                  output_drive_enable_n,
	output logic [DCF_DATA_W-1:0]       read_data,
	output logic                        read_data_oe_n,
	output logic                        full_flag_n,
	output logic                        almost_full_flag_n,
	output logic                        empty_flag_n,
	output logic                        almost_empty_flag_n
);

	// ----------------------------------------------------------------
	// Derived sizes
	// ----------------------------------------------------------------
	localparam int          AW      = $clog2(DEPTH);
	localparam int          PW      = AW + 1;
	localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
	localparam logic [AW-1:0] OFS_RST = AW'(DCF_OFFSET_DEF);

	if (!(DEPTH == 64 || DEPTH == 256 || DEPTH == 512 || DEPTH == 1024 ||
	      DEPTH == 2048 || DEPTH == DCF_DEPTH_MAX)) begin : g_depth_bad
		$error("dcf_fifo: unsupported DEPTH");
	end

	function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = '0;
		for (int i = PW - 1; i >= 0; i--) begin
			b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
		end
		gray2bin = b;
	endfunction

	logic [DCF_DATA_W-1:0] mem [DEPTH];

	// ----------------------------------------------------------------
	// Reset synchronisers, one per domain
	// ----------------------------------------------------------------
	logic [DCF_SYNC_STAGES-1:0] wr_rst_pipe;
	logic [DCF_SYNC_STAGES-1:0] rd_rst_pipe;
	wire                        wr_run = wr_rst_pipe[DCF_SYNC_STAGES-1];
	wire                        rd_run = rd_rst_pipe[DCF_SYNC_STAGES-1];

	always_ff @(posedge write_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			wr_rst_pipe <= '0;
		end else begin
			wr_rst_pipe <= {wr_rst_pipe[DCF_SYNC_STAGES-2:0], 1'b1};
		end
	end

	always_ff @(posedge read_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			rd_rst_pipe <= '0;
		end else begin
			rd_rst_pipe <= {rd_rst_pipe[DCF_SYNC_STAGES-2:0], 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// Mode capture
	// ----------------------------------------------------------------
	// No reset: strap taken by the clock during reset
	dcf_mode_t mode;

	always_ff @(posedge write_clock) begin
		if (!wr_run) begin
			mode <= write_enable_second_or_load ? DCF_MODE_DUAL : DCF_MODE_PROG;
		end
	end

	wire wr_dual      = (mode == DCF_MODE_DUAL);
	wire wr_load_n    = wr_dual | write_enable_second_or_load;
	wire wr_req_dual  = wr_dual & ~write_enable_a_n & write_enable_second_or_load;
	wire wr_req_prog  = ~wr_dual & ~write_enable_a_n & wr_load_n;
	wire ofs_wr       = ~wr_dual & ~write_enable_a_n & ~wr_load_n;

	// ----------------------------------------------------------------
	// Write domain
	// ----------------------------------------------------------------
	logic [PW-1:0]  wptr_bin;
	logic [PW-1:0]  wptr_gray;
	logic [PW-1:0]  rgray_s1;
	logic [PW-1:0]  rgray_s2;
	logic [PW-1:0]  rptr_bin;
	logic [PW-1:0]  rptr_gray;
	logic [AW-1:0]  ae_offset;
	logic [AW-1:0]  af_offset;
	dcf_ofs_t       wr_ofs_sel;
	dcf_wr_flags_t  wflags;

	// full blocks writes
	// Held off until the reset release has crossed
	wire            push        = (wr_req_dual | wr_req_prog) & wflags.full_n & wr_run;
	wire [PW-1:0]   next_wptr   = wptr_bin + PW'(push);
	// Stale read pointer only delays the full and almost-full release
	wire [PW-1:0]   rptr_w      = gray2bin(rgray_s2);
	wire [PW-1:0]   wr_level    = next_wptr - rptr_w;
	wire [PW-1:0]   af_limit    = DEPTH_P - PW'(af_offset);
	dcf_wr_flags_t  next_wflags;

	assign next_wflags.full_n        = (wr_level != DEPTH_P);
	assign next_wflags.almost_full_n = (wr_level < af_limit);

	always_ff @(posedge write_clock) begin
		if (push) begin
			mem[wptr_bin[AW-1:0]] <= write_data;
		end
	end

	always_ff @(posedge write_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			wptr_bin  <= '0;
			wptr_gray <= '0;
		end else if (wr_run) begin
			wptr_bin  <= next_wptr;
			wptr_gray <= bin2gray(next_wptr);
		end
	end

	always_ff @(posedge write_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			rgray_s1 <= '0;
			rgray_s2 <= '0;
		end else begin
			rgray_s1 <= rptr_gray;
			rgray_s2 <= rgray_s1;
		end
	end

	always_ff @(posedge write_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			wflags.full_n        <= DCF_FULL_N_RST;
			wflags.almost_full_n <= DCF_AFULL_N_RST;
		end else if (wr_run) begin
			wflags <= next_wflags;
		end
	end

	always_ff @(posedge write_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			ae_offset  <= OFS_RST;
			af_offset  <= OFS_RST;
			wr_ofs_sel <= DCF_OFS_EMPTY;
		end else if (wr_run & ofs_wr) begin
			unique case (wr_ofs_sel)
				DCF_OFS_EMPTY: begin
					ae_offset  <= AW'(write_data);
					wr_ofs_sel <= DCF_OFS_FULL;
				end
				DCF_OFS_FULL: begin
					af_offset  <= AW'(write_data);
					wr_ofs_sel <= DCF_OFS_EMPTY;
				end
			endcase
		end
	end

	assign full_flag_n        = wflags.full_n;
	assign almost_full_flag_n = wflags.almost_full_n;

	// ----------------------------------------------------------------
	// Crossing of quasi-static controls into read domain
	// ----------------------------------------------------------------
	// Offsets must be stable while the other side reads flags
	// Limitation: load offsets only while both ports idle
	logic [PW-1:0]  wgray_s1;
	logic [PW-1:0]  wgray_s2;
	logic [AW-1:0]  ae_ofs_s1;
	logic [AW-1:0]  ae_ofs_s2;
	logic [AW-1:0]  af_ofs_s1;
	logic [AW-1:0]  af_ofs_s2;
	logic           ofs_rd_req_w;
	logic           load_s1;
	logic           load_s2;

	always_ff @(posedge read_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			wgray_s1  <= '0;
			wgray_s2  <= '0;
			ae_ofs_s1 <= OFS_RST;
			ae_ofs_s2 <= OFS_RST;
			af_ofs_s1 <= OFS_RST;
			af_ofs_s2 <= OFS_RST;
			load_s1   <= 1'h0;
			load_s2   <= 1'h0;
		end else begin
			wgray_s1  <= wptr_gray;
			wgray_s2  <= wgray_s1;
			ae_ofs_s1 <= ae_offset;
			ae_ofs_s2 <= ae_ofs_s1;
			af_ofs_s1 <= af_offset;
			af_ofs_s2 <= af_ofs_s1;
			load_s1   <= ofs_rd_req_w;
			load_s2   <= load_s1;
		end
	end

	// Registered so one glitch-free bit crosses
	always_ff @(posedge write_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			ofs_rd_req_w <= 1'h0;
		end else begin
			ofs_rd_req_w <= ~wr_dual & ~wr_load_n & wr_run;
		end
	end

	// ----------------------------------------------------------------
	// Read domain
	// ----------------------------------------------------------------
	dcf_ofs_t       rd_ofs_sel;
	dcf_rd_flags_t  rflags;

	wire            rd_en       = ~read_enable_a_n & ~read_enable_b_n;
	// Load is seen one write edge and two read edges late
	wire            ofs_rd      = rd_en & load_s2;
	wire            pop         = rd_en & ~load_s2 & rflags.empty_n;
	wire [PW-1:0]   next_rptr   = rptr_bin + PW'(pop);
	wire [PW-1:0]   wptr_r      = gray2bin(wgray_s2);
	wire [PW-1:0]   rd_level    = wptr_r - next_rptr;
	dcf_rd_flags_t  next_rflags;

	assign next_rflags.empty_n        = (rd_level != '0);
	assign next_rflags.almost_empty_n = (rd_level > PW'(ae_ofs_s2));

	always_ff @(posedge read_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			rptr_bin  <= '0;
			rptr_gray <= '0;
		end else if (rd_run) begin
			rptr_bin  <= next_rptr;
			rptr_gray <= bin2gray(next_rptr);
		end
	end

	always_ff @(posedge read_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			rflags.empty_n        <= DCF_EMPTY_N_RST;
			rflags.almost_empty_n <= DCF_AEMPTY_N_RST;
		end else if (rd_run) begin
			rflags <= next_rflags;
		end
	end

	always_ff @(posedge read_clock or negedge master_reset_n) begin
		if (!master_reset_n) begin
			read_data  <= '0;
			rd_ofs_sel <= DCF_OFS_EMPTY;
		end else if (rd_run) begin
			if (pop) begin
				read_data <= mem[rptr_bin[AW-1:0]];
			end else if (ofs_rd) begin
				unique case (rd_ofs_sel)
					DCF_OFS_EMPTY: begin
						read_data  <= DCF_DATA_W'(ae_ofs_s2);
						rd_ofs_sel <= DCF_OFS_FULL;
					end
					DCF_OFS_FULL: begin
						read_data  <= DCF_DATA_W'(af_ofs_s2);
						rd_ofs_sel <= DCF_OFS_EMPTY;
					end
				endcase
			end
		end
	end

	assign empty_flag_n        = rflags.empty_n;
	assign almost_empty_flag_n = rflags.almost_empty_n;

	assign read_data_oe_n = output_drive_enable_n;

endmodule

`default_nettype wire

// *** sim/dcf_fifo_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_monitor
	import dcf_pkg::*;
(
	input wire logic                  write_clock,
	input wire logic                  read_clock,
	input wire logic                  master_reset_n,
	input wire logic                  write_enable_a_n,
	input wire logic                  write_enable_second_or_load,
	input wire logic                  read_enable_a_n,
	input wire logic                  read_enable_b_n,
	input wire logic                  output_drive_enable_n,
	input wire logic [DCF_DATA_W-1:0] read_data,
	input wire logic                  read_data_oe_n,
	input wire logic                  full_flag_n,
	input wire logic                  almost_full_flag_n,
	input wire logic                  empty_flag_n,
	input wire logic                  almost_empty_flag_n
);
	rst_flags_a: assert property (@(posedge write_clock) disable iff (!master_reset_n)
		$rose(master_reset_n) |-> full_flag_n && almost_full_flag_n && !empty_flag_n && !almost_empty_flag_n)
		else $error("flags wrong at reset release");
	oe_follow_a: assert property (@(posedge read_clock) disable iff (!master_reset_n)
		read_data_oe_n == output_drive_enable_n) else $error("output enable not followed");
	full_cause_a: assert property (@(posedge write_clock) disable iff (!master_reset_n)
		$fell(full_flag_n) |-> !$past(write_enable_a_n)) else $error("full without write");
	empty_cause_a: assert property (@(posedge read_clock) disable iff (!master_reset_n)
		$fell(empty_flag_n) |-> !$past(read_enable_a_n) && !$past(read_enable_b_n))
		else $error("empty without read");
	idle_hold_a: assert property (@(posedge read_clock) disable iff (!master_reset_n)
		read_enable_a_n || read_enable_b_n |=> $stable(read_data)) else $error("data moved without read");
	// Load must be high long enough that no offset read is in flight
	empty_hold_a: assert property (@(posedge read_clock) disable iff (!master_reset_n)
		write_enable_second_or_load [*4] ##0 (!empty_flag_n && !read_enable_a_n && !read_enable_b_n)
		|=> $stable(read_data)) else $error("read while empty");
	full_af_a: assert property (@(posedge write_clock) disable iff (!master_reset_n)
		!full_flag_n |-> !almost_full_flag_n) else $error("full but not almost full");
	empty_ae_a: assert property (@(posedge read_clock) disable iff (!master_reset_n)
		!empty_flag_n |-> !almost_empty_flag_n) else $error("empty but not almost empty");
endmodule
`default_nettype wire

// *** sim/dcf_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcf_peer
	import dcf_pkg::*;
(
	input wire logic                  clk,
	input wire logic [DCF_DATA_W-1:0] read_data,
	output var logic [DCF_DATA_W-1:0] write_data,
	output var logic                  write_enable_a_n,
	output var logic                  write_enable_second_or_load,
	output var logic                  read_enable_a_n,
	output var logic                  read_enable_b_n
);
	logic [DCF_DATA_W-1:0] got[$];
	initial begin
		write_data = '0;
		write_enable_a_n = 1'b1;
		write_enable_second_or_load = 1'b1;
		read_enable_a_n = 1'b1;
		read_enable_b_n = 1'b1;
	end
	task automatic push_run(input int n, input logic [DCF_DATA_W-1:0] base);
		for (int i = 0; i <= n; i++) begin
			@(posedge clk);
			write_enable_a_n <= 1'(i >= n);
			// Idle bus shows the inverse, never a stale word
			write_data <= (i < n) ? base + DCF_DATA_W'(i) : ~write_data;
		end
	endtask
	task automatic pop_run(input int n);
		for (int i = 0; i <= n; i++) begin
			@(posedge clk);
			read_enable_a_n <= 1'(i >= n);
			read_enable_b_n <= 1'(i >= n);
			#1;
			if (i > 0)
				got.push_back(read_data);
		end
	endtask
	task automatic load_offsets(input logic [DCF_DATA_W-1:0] ae, input logic [DCF_DATA_W-1:0] af);
		@(posedge clk);
		write_enable_second_or_load <= 1'b0;
		write_enable_a_n <= 1'b0;
		write_data <= ae;
		@(posedge clk);
		write_data <= af;
		@(posedge clk);
		write_enable_a_n <= 1'b1;
		write_enable_second_or_load <= 1'b1;
		write_data <= ~af;
	endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import dcf_pkg::*;
;
	localparam int DEPTH = 64;
	logic                  sys_clk;
	logic                  rstn;
	logic                  oe_n;
	logic [DCF_DATA_W-1:0] wd;
	logic [DCF_DATA_W-1:0] rd;
	logic                  wea_n, pin, rea_n, reb_n, oeo_n, full_n, afull_n, empty_n, aempty_n;
	int                    fail_count = 0;
	int                    checks = 0;
	int                    cycles = 0;
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	dcf_fifo #(.DEPTH(DEPTH)) DUT (.write_clock(sys_clk), .read_clock(sys_clk), .master_reset_n(rstn),
		.write_data(wd), .write_enable_a_n(wea_n), .write_enable_second_or_load(pin),
		.read_enable_a_n(rea_n), .read_enable_b_n(reb_n), .output_drive_enable_n(oe_n), .read_data(rd),
		.read_data_oe_n(oeo_n), .full_flag_n(full_n), .almost_full_flag_n(afull_n), .empty_flag_n(empty_n),
		.almost_empty_flag_n(aempty_n));
	dcf_peer peer (.clk(sys_clk), .read_data(rd), .write_data(wd), .write_enable_a_n(wea_n),
		.write_enable_second_or_load(pin), .read_enable_a_n(rea_n), .read_enable_b_n(reb_n));
	task automatic report_and_stop();
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [DCF_DATA_W-1:0] seen, input logic [DCF_DATA_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic settle();
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic do_reset(input logic strap);
		@(posedge sys_clk);
		rstn <= 1'b0;
		peer.write_enable_second_or_load <= strap;
		repeat (5) @(posedge sys_clk);
		check("full in reset", 9'(full_n), 9'h001);
		check("afull in reset", 9'(afull_n), 9'h001);
		check("empty in reset", 9'(empty_n), 9'h000);
		check("aempty in reset", 9'(aempty_n), 9'h000);
		rstn <= 1'b1;
		settle();
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		rstn = 1'b0;
		oe_n = 1'b0;
		do_reset(1'b1);
		check("oe on", 9'(oeo_n), 9'h000);
		@(posedge sys_clk);
		peer.write_enable_second_or_load <= 1'b0;
		peer.push_run(1, 9'h0aa);
		settle();
		check("enable b low", 9'(empty_n), 9'h000);
		@(posedge sys_clk);
		peer.write_enable_second_or_load <= 1'b1;
		peer.push_run(DEPTH - 8, 9'h100);
		settle();
		check("afull at 56", 9'(afull_n), 9'h001);
		peer.push_run(1, 9'h138);
		settle();
		check("afull at 57", 9'(afull_n), 9'h000);
		peer.push_run(7, 9'h139);
		peer.push_run(1, 9'h0ff);
		settle();
		check("full", 9'(full_n), 9'h000);
		peer.pop_run(DEPTH - 8);
		settle();
		check("aempty at 8", 9'(aempty_n), 9'h001);
		peer.pop_run(1);
		settle();
		check("aempty at 7", 9'(aempty_n), 9'h000);
		peer.pop_run(8);
		settle();
		check("empty", 9'(empty_n), 9'h000);
		for (int k = 0; k <= DEPTH; k++)
			check("word", peer.got[k], 9'h100 + 9'(k < DEPTH ? k : DEPTH - 1));
		@(posedge sys_clk);
		oe_n <= 1'b1;
		@(posedge sys_clk);
		check("oe off", 9'(oeo_n), 9'h001);
		peer.push_run(2, 9'h0bb);
		do_reset(1'b0);
		peer.load_offsets(9'h002, 9'h003);
		settle();
		peer.got.delete();
		peer.push_run(3, 9'h020);
		settle();
		check("aempty at 3", 9'(aempty_n), 9'h001);
		peer.push_run(DEPTH - 7, 9'h040);
		settle();
		check("afull at 60", 9'(afull_n), 9'h001);
		peer.push_run(1, 9'h079);
		settle();
		check("afull at 61", 9'(afull_n), 9'h000);
		peer.pop_run(1);
		check("first after reset", peer.got[0], 9'h020);
		@(posedge sys_clk);
		peer.write_enable_second_or_load <= 1'b0;
		repeat (3) @(posedge sys_clk);
		peer.pop_run(2);
		@(posedge sys_clk);
		peer.write_enable_second_or_load <= 1'b1;
		check("empty offset back", peer.got[1], 9'h002);
		check("full offset back", peer.got[2], 9'h003);
		report_and_stop();
	end
endmodule
bind dcf_fifo dcf_fifo_monitor u_mon (
	.write_clock                 (write_clock),
	.read_clock                  (read_clock),
	.master_reset_n              (master_reset_n),
	.write_enable_a_n            (write_enable_a_n),
	.write_enable_second_or_load (write_enable_second_or_load),
	.read_enable_a_n             (read_enable_a_n),
	.read_enable_b_n             (read_enable_b_n),
	.output_drive_enable_n       (output_drive_enable_n),
	.read_data                   (read_data),
	.read_data_oe_n              (read_data_oe_n),
	.full_flag_n                 (full_flag_n),
	.almost_full_flag_n          (almost_full_flag_n),
	.empty_flag_n                (empty_flag_n),
	.almost_empty_flag_n         (almost_empty_flag_n)
);
`default_nettype wire
